// [hw/optbyte_defines.svh]
`ifndef OPTBYTE_DEFINES_SVH
`define OPTBYTE_DEFINES_SVH

// erased flash content and protected-clear erase value
`define OB_ERASED_VAL 8'hff
`define OB_WIPE_VAL 8'h00
// byte 0 fields
`define OB0_OPAMP3_BIT 1
`define OB0_PROTECT_BIT 0
// byte 1 fields
`define OB1_CLKFILT_BIT 7
`define OB1_OSC_HI 6
`define OB1_OSC_LO 4
`define OB1_LVD_HI 3
`define OB1_LVD_LO 2
`define OB1_HALT_BIT 1
`define OB1_WDG_BIT 0
// register map on the local port
`define OB_ADDR_BYTE0 2'h0
`define OB_ADDR_BYTE1 2'h1
`define OB_ADDR_STATUS 2'h2
// status bits
`define OB_ST_LOADED 0
`define OB_ST_PROG 1
`define OB_ST_WIPE 2

`endif

// [hw/optbyte_pkg.sv]
package optbyte_pkg;
  typedef enum logic [2:0] {
    OSC_HS, OSC_MS, OSC_MP, OSC_LP, OSC_EXT_RC, OSC_INT_RC, OSC_EXT_CLK
  } osc_sel_t;
  typedef enum logic [2:0] {
    LVD_LOW, LVD_MID, LVD_HIGH, LVD_OFF
  } lvd_sel_t;
  typedef enum {
    ST_LOAD, ST_RUN, ST_WIPE
  } ctl_state_t;
endpackage

// [hw/option_byte_config_decoder.sv]
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "optbyte_defines.svh"

module option_byte_config_decoder
  import optbyte_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_prog_mode,
  input wire logic [7:0] i_nv_byte0,
  input wire logic [7:0] i_nv_byte1,
  input wire logic i_nv_erased,
  input wire logic [1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic [7:0] o_nv_wdata0,
  output logic [7:0] o_nv_wdata1,
  output logic o_nv_write,
  output logic o_mem_wipe,
  output logic o_opamp3_enable,
  output logic o_readout_protect,
  output logic o_clock_filter_off,
  output logic [2:0] o_main_osc_select,
  output osc_sel_t o_osc_kind,
  output logic [1:0] o_low_voltage_threshold_select,
  output lvd_sel_t o_lvd_kind,
  output logic o_halt_reset_select,
  output logic o_watchdog_type_select
);

  // timing at a glance:
  //   edge 1 after reset: shadows take the stored bytes
  //   edge 2 after reset: decoded outputs follow
  //   programming mode counts two edges after the pin rises
  //   a write lands in the shadow at its strobe edge, outputs one later
  //   a wipe leaves one dead cycle in which writes are dropped

  // programming-mode pin comes from outside; two-stage synchroniser
  // only the second stage is read, the first may still be settling
  logic prog_s1_q;
  logic prog_s2_q;
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      prog_s1_q <= 1'b0;
      prog_s2_q <= 1'b0;
    end else begin
      prog_s1_q <= i_prog_mode;
      prog_s2_q <= prog_s1_q;
    end
  end

  // option byte shadow copies and control state
  ctl_state_t state_q;
  logic [7:0] ob0_q;
  logic [7:0] ob1_q;
  logic loaded_q;

  // erased or unprogrammed storage reads as ffh
  logic [7:0] nv0;
  logic [7:0] nv1;
  assign nv0 = i_nv_erased ? `OB_ERASED_VAL : i_nv_byte0;
  assign nv1 = i_nv_erased ? `OB_ERASED_VAL : i_nv_byte1;

  logic wr_ok;
  assign wr_ok = i_wr && prog_s2_q;
  // a write dropping protection must wipe first
  logic unprotect;
  assign unprotect = wr_ok && (i_addr == `OB_ADDR_BYTE0) && ob0_q[`OB0_PROTECT_BIT]
    && !i_wdata[`OB0_PROTECT_BIT];

  // state only tells load, run and the one dead cycle after a wipe
  logic load_now;
  logic wipe_now;
  logic wr_byte0;
  logic wr_byte1;
  assign load_now = (state_q == ST_LOAD);
  // a wipe is honoured only while running, never twice in a row
  assign wipe_now = unprotect && (state_q == ST_RUN);
  // plain byte writes; a write in the wipe cycle is dropped on purpose
  assign wr_byte0 = wr_ok && (state_q == ST_RUN) && (i_addr == `OB_ADDR_BYTE0);
  assign wr_byte1 = wr_ok && (state_q == ST_RUN) && (i_addr == `OB_ADDR_BYTE1);

  // control sequence: one load cycle after reset, then run
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      state_q <= ST_LOAD;
    end else begin
      case (state_q)
        ST_LOAD: begin
          state_q <= ST_RUN;
        end
        ST_RUN: begin
          if (wipe_now) begin
            state_q <= ST_WIPE;
          end
        end
        ST_WIPE: begin
          state_q <= ST_RUN;
        end
        default: begin
          state_q <= ST_LOAD;
        end
      endcase
    end
  end

  // byte 0 shadow; storage is sampled once, so later input noise is ignored
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      ob0_q <= `OB_ERASED_VAL;
    end else if (load_now) begin
      ob0_q <= nv0;
    end else if (wipe_now) begin
      // option byte goes to 00h with the rest, so protection drops with it
      ob0_q <= `OB_WIPE_VAL;
    end else if (wr_byte0) begin
      ob0_q <= i_wdata;
    end
  end

  // byte 1 shadow; the wipe clears it too, the whole array goes to 00h
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      ob1_q <= `OB_ERASED_VAL;
    end else if (load_now) begin
      ob1_q <= nv1;
    end else if (wipe_now) begin
      ob1_q <= `OB_WIPE_VAL;
    end else if (wr_byte1) begin
      ob1_q <= i_wdata;
    end
  end

  // loaded flag for the status word; only a reset clears it
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      loaded_q <= 1'b0;
    end else if (load_now) begin
      loaded_q <= 1'b1;
    end
  end

  // storage write pulse; one cycle per accepted byte write
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_nv_write <= 1'b0;
    end else begin
      o_nv_write <= wr_byte0 || wr_byte1;
    end
  end

  // whole-array erase pulse; the storage side gives it priority over a write
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_mem_wipe <= 1'b0;
    end else begin
      o_mem_wipe <= wipe_now;
    end
  end

  // both bytes go out together, so the far side never needs a merge;
  // unprotect beats the address decode, the wipe image is all zero
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_nv_wdata0 <= `OB_ERASED_VAL;
    end else if (unprotect) begin
      o_nv_wdata0 <= `OB_WIPE_VAL;
    end else if (i_addr == `OB_ADDR_BYTE0) begin
      o_nv_wdata0 <= i_wdata;
    end else begin
      o_nv_wdata0 <= ob0_q;
    end
  end

  // byte 1 image toward storage, same scheme as byte 0
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_nv_wdata1 <= `OB_ERASED_VAL;
    end else if (unprotect) begin
      o_nv_wdata1 <= `OB_WIPE_VAL;
    end else if (i_addr == `OB_ADDR_BYTE1) begin
      o_nv_wdata1 <= i_wdata;
    end else begin
      o_nv_wdata1 <= ob1_q;
    end
  end

  // status word: loaded, programming mode seen, wipe in progress
  logic [7:0] status_word;
  always_comb begin
    status_word = 8'h00;
    status_word[`OB_ST_LOADED] = loaded_q;
    status_word[`OB_ST_PROG] = prog_s2_q;
    status_word[`OB_ST_WIPE] = (state_q == ST_WIPE);
  end

  // option bytes read back as zero outside programming mode
  logic [7:0] byte0_view;
  logic [7:0] byte1_view;
  assign byte0_view = prog_s2_q ? ob0_q : 8'h00;
  assign byte1_view = prog_s2_q ? ob1_q : 8'h00;

  // read port: data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        `OB_ADDR_BYTE0: begin
          o_rdata <= byte0_view;
        end
        `OB_ADDR_BYTE1: begin
          o_rdata <= byte1_view;
        end
        `OB_ADDR_STATUS: begin
          o_rdata <= status_word;
        end
        default: begin
          o_rdata <= 8'h00;
        end
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // decoded settings, one register each so every output comes off a flop;
  // they lag the shadows by one cycle, harmless as the bytes only move at
  // load, on a programming-mode write or on a wipe
  // reset levels are the erased-byte decode, except the byte 0 pair
  localparam logic [7:0] ERASED_BYTE = `OB_ERASED_VAL;

  // op-amp three enable, a plain level for the analog side
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_opamp3_enable <= 1'b0;
    end else begin
      o_opamp3_enable <= ob0_q[`OB0_OPAMP3_BIT];
    end
  end

  // read-out protection level for the memory access guard
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_readout_protect <= 1'b0;
    end else begin
      o_readout_protect <= ob0_q[`OB0_PROTECT_BIT];
    end
  end

  // clock filter control; a one turns the filter off
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_clock_filter_off <= ERASED_BYTE[`OB1_CLKFILT_BIT];
    end else begin
      o_clock_filter_off <= ob1_q[`OB1_CLKFILT_BIT];
    end
  end

  // raw oscillator field, passed on untouched
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_main_osc_select <= ERASED_BYTE[`OB1_OSC_HI:`OB1_OSC_LO];
    end else begin
      o_main_osc_select <= ob1_q[`OB1_OSC_HI:`OB1_OSC_LO];
    end
  end

  // raw detector field, passed on untouched
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_low_voltage_threshold_select <= ERASED_BYTE[`OB1_LVD_HI:`OB1_LVD_LO];
    end else begin
      o_low_voltage_threshold_select <= ob1_q[`OB1_LVD_HI:`OB1_LVD_LO];
    end
  end

  // reset on halt while the watchdog runs
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_halt_reset_select <= ERASED_BYTE[`OB1_HALT_BIT];
    end else begin
      o_halt_reset_select <= ob1_q[`OB1_HALT_BIT];
    end
  end

  // watchdog type; zero keeps it always on in hardware
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_watchdog_type_select <= ERASED_BYTE[`OB1_WDG_BIT];
    end else begin
      o_watchdog_type_select <= ob1_q[`OB1_WDG_BIT];
    end
  end

  // oscillator kind; both external resistor codes fold into one kind,
  // so a consumer need not know that the low bit is a don't-care there
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_osc_kind <= OSC_EXT_CLK;
    end else begin
      case (ob1_q[`OB1_OSC_HI:`OB1_OSC_LO])
        3'h7: o_osc_kind <= OSC_EXT_CLK;
        3'h6: o_osc_kind <= OSC_INT_RC;
        3'h5, 3'h4: o_osc_kind <= OSC_EXT_RC;
        3'h3: o_osc_kind <= OSC_LP;
        3'h2: o_osc_kind <= OSC_MP;
        3'h1: o_osc_kind <= OSC_MS;
        default: o_osc_kind <= OSC_HS;
      endcase
    end
  end

  // detector kind; all ones switches the detector off,
  // the other three codes pick a threshold from high to low
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_lvd_kind <= LVD_OFF;
    end else begin
      case (ob1_q[`OB1_LVD_HI:`OB1_LVD_LO])
        2'h3: o_lvd_kind <= LVD_OFF;
        2'h2: o_lvd_kind <= LVD_HIGH;
        2'h1: o_lvd_kind <= LVD_MID;
        default: o_lvd_kind <= LVD_LOW;
      endcase
    end
  end

endmodule

// [verification/optbyte_assertions.sv]
`timescale 1ns/100ps
module optbyte_chk (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_prog_mode,
  input wire logic [1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic o_nv_write,
  input wire logic o_mem_wipe,
  input wire logic o_opamp3_enable,
  input wire logic o_readout_protect,
  input wire logic o_clock_filter_off,
  input wire logic [2:0] o_main_osc_select,
  input wire logic [1:0] o_low_voltage_threshold_select,
  input wire logic o_halt_reset_select,
  input wire logic o_watchdog_type_select
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  // decode packed back in stored bit order
  wire [7:0] cfg = {o_clock_filter_off, o_main_osc_select, o_low_voltage_threshold_select,
    o_halt_reset_select, o_watchdog_type_select};
  wire [1:0] b0 = {o_opamp3_enable, o_readout_protect};
  rst_dflt_a: assert property ($past(i_srst) |-> cfg == 8'hff) else $error("dflt");
  prog_only_a: assert property (o_nv_write |-> $past(i_wr) && $past(i_prog_mode, 3))
    else $error("prog");
  cfg_load_a: assert property (o_nv_write && $past(i_addr) == 2'h1 |=>
    cfg == $past(i_wdata, 2)) else $error("cfg");
  b0_load_a: assert property (o_nv_write && !o_mem_wipe && $past(i_addr) == 2'h0 |=>
    b0 == 2'($past(i_wdata, 2))) else $error("b0");
  wipe_src_a: assert property (o_mem_wipe |-> $past(i_addr) == 2'h0 && $past(i_wr))
    else $error("wipe");
  wipe_clr_a: assert property (o_mem_wipe |=> cfg == 8'h00 && b0 == 2'h0)
    else $error("clr");
  wipe_one_a: assert property (o_mem_wipe |=> !o_mem_wipe) else $error("one");
  cfg_hold_a: assert property (!$past(o_nv_write) && !$past(o_mem_wipe)
    && !$past(i_srst, 3) |-> $stable(cfg) && $stable(b0)) else $error("hold");
endmodule
bind option_byte_config_decoder optbyte_chk i_chk (.*);

// [verification/optbyte_store.sv]
`timescale 1ns/100ps
module optbyte_store (
  input wire logic i_clk,
  input wire logic [7:0] i_w0,
  input wire logic [7:0] i_w1,
  input wire logic i_we,
  input wire logic i_wipe,
  output logic [7:0] o_b0 = 8'h5a,
  output logic [7:0] o_b1 = 8'h5a,
  output logic o_blank = 1'b1
);
  // blank cells hold junk, so the design must honour the blank flag
  always @(posedge i_clk) begin
    o_blank <= o_blank & !(i_wipe | i_we);
    if (i_wipe) {o_b0, o_b1} <= 16'h0000;
    else if (i_we) {o_b0, o_b1} <= {i_w0, i_w1};
  end
endmodule

// [verification/option_byte_config_decoder_tb.sv]
`timescale 1ns/100ps
module option_byte_config_decoder_tb;
  import optbyte_pkg::*;
  logic i_core_clk = 1'b0, i_srst = 1'b1, i_prog_mode = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic i_nv_erased, o_nv_write, o_mem_wipe, o_opamp3_enable, o_readout_protect;
  logic o_clock_filter_off, o_halt_reset_select, o_watchdog_type_select;
  logic [1:0] i_addr = 2'h0, o_low_voltage_threshold_select;
  logic [2:0] o_main_osc_select;
  logic [7:0] i_wdata = 8'h00, i_nv_byte0, i_nv_byte1, o_rdata, o_nv_wdata0, o_nv_wdata1, v, rdq;
  osc_sel_t o_osc_kind;
  lvd_sel_t o_lvd_kind;
  logic [31:0] rnd = 32'h0b62c921;
  int err_total = 0, cmp_count = 0, cyc = 0;
  wire [7:0] cfg = {o_clock_filter_off, o_main_osc_select, o_low_voltage_threshold_select,
    o_halt_reset_select, o_watchdog_type_select};
  option_byte_config_decoder i_option_byte_config_decoder (.*);
  optbyte_store i_optbyte_store (.i_clk(i_core_clk), .i_w0(o_nv_wdata0), .i_w1(o_nv_wdata1),
    .i_we(o_nv_write), .i_wipe(o_mem_wipe), .o_b0(i_nv_byte0), .o_b1(i_nv_byte1),
    .o_blank(i_nv_erased));
  // 100 ns period; the run needs about 110 cycles, so 1000 means a hang
  always #50 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 1000) complete_run(1);
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  // both resistor codes fold into one kind
  function automatic osc_sel_t osc_exp(input logic [2:0] s);
    return s == 3'h7 ? OSC_EXT_CLK : s == 3'h6 ? OSC_INT_RC : s[2] ? OSC_EXT_RC : osc_sel_t'(s);
  endfunction
  task automatic chk(input logic [7:0] e, input logic [7:0] g, input string n);
    cmp_count++;
    err_total += int'(g !== e);
    if (g !== e) $display("BAD %s exp %h got %h", n, e, g);
  endtask
  // one strobe cycle, grab read data, then let the decode settle
  task automatic bus(input logic w, input logic [1:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    {i_wr, i_rd} <= {w, !w};
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    {i_wr, i_rd} <= 2'b00;
    #1 rdq = o_rdata;
    repeat (2) @(posedge i_core_clk);
    #1;
  endtask
  task automatic complete_run(input int late);
    err_total += late;
    $display("checks %0d bad %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge i_core_clk);
    i_srst <= 1'b0;
    repeat (3) @(posedge i_core_clk);
    chk(8'hff, cfg, "blank");
    bus(1'b1, 2'h1, 8'h00);
    bus(1'b0, 2'h1, 8'h00);
    chk(8'hff, cfg, "locked");
    chk(8'h00, rdq, "locked rd");
    $display("lock test done");
    i_prog_mode <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    for (int i = 0; i < 8; i++) begin
      rnd = xs(rnd);
      v = {rnd[7], i[2:0], i[1:0], rnd[1:0]};
      bus(1'b1, 2'h1, v);
      chk(v, cfg, "cfg");
      chk(8'(osc_exp(v[6:4])), 8'(o_osc_kind), "osc");
      chk(8'(v[3:2]), 8'(o_lvd_kind), "lvd");
      bus(1'b0, 2'h1, 8'h00);
      chk(v, rdq, "rd");
    end
    bus(1'b1, 2'h0, 8'hff);
    chk(8'h03, {6'h00, o_opamp3_enable, o_readout_protect}, "b0");
    bus(1'b1, 2'h0, 8'hfe);
    chk(8'h00, cfg, "wiped");
    $display("decode test done");
    rnd = xs(rnd);
    v = rnd[15:8];
    bus(1'b1, 2'h1, v);
    @(posedge i_core_clk);
    i_srst <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    i_srst <= 1'b0;
    repeat (3) @(posedge i_core_clk);
    chk(v, cfg, "reload");
    chk(8'h00, {6'h00, o_opamp3_enable, o_readout_protect}, "reload b0");
    bus(1'b0, 2'h2, 8'h00);
    chk(8'h03, rdq, "status");
    $display("reload test done");
    complete_run(0);
  end
endmodule
